//--- core/rac_pkg.sv
// Constants and types of the alarm, timebase and serial control block
package rac_pkg;
	localparam logic [7:0]  ADDR_CTRL   = 8'h0E;
	localparam logic [7:0]  ADDR_STAT   = 8'h0F;
	localparam logic [6:0]  SLAVE_ADDR  = 7'h68;
	localparam logic [7:0]  CTRL_RESET  = 8'h98;
	localparam logic [1:0]  FLAGS_RESET = 2'h0;
	localparam logic [5:0]  STAT_PAD    = 6'h00;
	localparam logic [7:0]  SEC_ZERO    = 8'h00;
	localparam logic [3:0]  BYTE_BITS   = 4'h8;
	localparam int          SYNC_DEPTH  = 3;
	localparam int          SYNC_PINS   = 3;
	// Terminal counts, one less than the input rate
	localparam logic [14:0] DIV_32K     = 15'h7FFF;
	localparam logic [14:0] DIV_8K      = 15'h1FFF;
	localparam logic [14:0] DIV_60      = 15'h003B;
	localparam logic [14:0] DIV_50      = 15'h0031;
	localparam logic [1:0]  SEL_32K     = 2'h0;
	localparam logic [1:0]  SEL_8K      = 2'h1;
	localparam logic [1:0]  SEL_60      = 2'h2;
	localparam logic [1:0]  RATE_1HZ    = 2'h0;
	localparam logic [1:0]  RATE_1K     = 2'h1;
	localparam logic [1:0]  RATE_4K     = 2'h2;
	localparam int          TAP_1K      = 4;
	localparam int          TAP_4K      = 2;
	localparam int          TAP_8K      = 1;

	typedef struct packed {
		logic timebase_enable;
		logic input_divider_select_hi;
		logic input_divider_select_lo;
		logic square_rate_select_hi;
		logic square_rate_select_lo;
		logic output_routing_select;
		logic second_alarm_irq_enable;
		logic first_alarm_irq_enable;
	} rac_ctrl_t;

	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] day;
		logic [7:0] date;
	} rac_time_t;

	typedef struct packed {
		logic       second_alarm_minute_mask;
		logic [6:0] min;
		logic       second_alarm_hour_mask;
		logic [6:0] hour;
		logic       second_alarm_daydate_mask;
		logic       weekday_or_monthday_select;
		logic [5:0] daydate;
	} rac_alarm2_t;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_ADDR  = 6'h02,
		ST_ACK   = 6'h04,
		ST_WRITE = 6'h08,
		ST_READ  = 6'h10,
		ST_MACK  = 6'h20
	} rac_bus_st_t;
endpackage

//--- core/rac_timebase.sv
// Timebase divider: one-second tick and square wave
`timescale 1ns/100ps
`default_nettype none
module rac_timebase (
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       reset_i,
	// Timebase edge and settings
	input  wire logic       tb_edge_i,
	input  wire logic       enable_i,
	input  wire logic [1:0] div_sel_i,
	input  wire logic [1:0] rate_sel_i,
	// Results
	output logic            tick_o,
	output logic            sqw_o
);
	import rac_pkg::*;

	logic [14:0] cnt_reg;
	logic [14:0] cnt_next;
	logic        tick_reg;
	logic        tick_next;
	logic        sqw_reg;
	logic        sqw_next;

	function automatic logic [14:0] last_count(input logic [1:0] sel);
		case (sel)
			SEL_32K: last_count = DIV_32K;
			SEL_8K:  last_count = DIV_8K;
			SEL_60:  last_count = DIV_60;
			default: last_count = DIV_50;
		endcase
	endfunction

	always_comb begin
		cnt_next  = cnt_reg;
		tick_next = 1'b0;
		if (!enable_i) begin
			cnt_next = '0;
		end else if (tb_edge_i) begin
			if (cnt_reg >= last_count(div_sel_i)) begin
				cnt_next  = '0;
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 15'h0001;
			end
		end
		if (div_sel_i != SEL_32K || rate_sel_i == RATE_1HZ) begin
			sqw_next = cnt_reg > (last_count(div_sel_i) >> 1);
		end else if (rate_sel_i == RATE_1K) begin
			sqw_next = cnt_reg[TAP_1K];
		end else if (rate_sel_i == RATE_4K) begin
			sqw_next = cnt_reg[TAP_4K];
		end else begin
			sqw_next = cnt_reg[TAP_8K];
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			cnt_reg  <= '0;
			tick_reg <= 1'b0;
			sqw_reg  <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
			sqw_reg  <= sqw_next;
		end
	end

	assign tick_o = tick_reg;
	assign sqw_o  = sqw_reg;
endmodule
`default_nettype wire

//--- core/rac_rtc_ctrl.sv
// Alarm, square-wave routing and serial-bus register control of the clock device
`timescale 1ns/100ps
`default_nettype none
module rac_rtc_ctrl (
	// Clock and reset
	input  wire logic                 clock_i,
	input  wire logic                 reset_i,
	// Timebase pin
	input  wire logic                 timebase_i,
	// Serial bus pins
	input  wire logic                 scl_i,
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe_o,
	// Shared square-wave or interrupt pin
	output logic                      square_or_irq_out_o,
	// Timekeeping side
	input  wire rac_pkg::rac_time_t   time_i,
	input  wire rac_pkg::rac_alarm2_t alarm2_cfg_i,
	input  wire logic                 first_alarm_match_i,
	output logic                      second_tick_o,
	// Registers held outside
	output logic [7:0]                reg_ptr_o,
	input  wire logic [7:0]           ext_rdata_i,
	output logic                      ext_wr_o,
	output logic [7:0]                ext_waddr_o,
	output logic [7:0]                ext_wdata_o
);
	import rac_pkg::*;

	// Pin synchronisers: index 0 timebase, 1 clock line, 2 data line
	logic [SYNC_DEPTH-1:0] sync_reg  [SYNC_PINS];
	logic [SYNC_DEPTH-1:0] sync_next [SYNC_PINS];
	logic [SYNC_PINS-1:0]  lvl_reg;
	logic [SYNC_PINS-1:0]  lvl_next;
	logic [SYNC_PINS-1:0]  pin_raw;
	logic                  tb_rise;
	logic                  scl_rise;
	logic                  scl_fall;
	logic                  start_ev;
	logic                  stop_ev;

	assign pin_raw = {sda_i, scl_i, timebase_i};

	generate
		for (genvar p = 0; p < SYNC_PINS; p++) begin : g_sync
			always_comb begin
				sync_next[p] = {sync_reg[p][SYNC_DEPTH-2:0], pin_raw[p]};
				lvl_next[p]  = (sync_reg[p][1] == sync_reg[p][2]) ? sync_reg[p][2] : lvl_reg[p];
			end
			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					sync_reg[p] <= '1;
					lvl_reg[p]  <= 1'b1;
				end else begin
					sync_reg[p] <= sync_next[p];
					lvl_reg[p]  <= lvl_next[p];
				end
			end
		end
	endgenerate

	assign tb_rise  = lvl_next[0] && !lvl_reg[0];
	assign scl_rise = lvl_next[1] && !lvl_reg[1];
	assign scl_fall = !lvl_next[1] && lvl_reg[1];
	assign start_ev = lvl_reg[1] && lvl_next[1] && lvl_reg[2] && !lvl_next[2];
	assign stop_ev  = lvl_reg[1] && lvl_next[1] && !lvl_reg[2] && lvl_next[2];

	// Control, flags and divider
	rac_ctrl_t  ctrl_reg;
	rac_ctrl_t  ctrl_next;
	logic [1:0] flag_reg;
	logic [1:0] flag_next;
	logic [1:0] alarm_set;
	logic       tick;
	logic       sqw;
	logic       tick_d_reg;
	logic       out_reg;
	logic       out_next;
	logic       a2_now;

	rac_timebase u_timebase (
		.clock_i    (clock_i),
		.reset_i    (reset_i),
		.tb_edge_i  (tb_rise),
		.enable_i   (ctrl_reg.timebase_enable),
		.div_sel_i  ({ctrl_reg.input_divider_select_hi, ctrl_reg.input_divider_select_lo}),
		.rate_sel_i ({ctrl_reg.square_rate_select_hi, ctrl_reg.square_rate_select_lo}),
		.tick_o     (tick),
		.sqw_o      (sqw)
	);

	function automatic logic a2_hit(input rac_time_t t, input rac_alarm2_t a);
		logic mn;
		logic hr;
		logic dd;
		mn = t.min[6:0] == a.min;
		hr = t.hour[6:0] == a.hour;
		dd = a.weekday_or_monthday_select ? (t.day[5:0] == a.daydate)
			: (t.date[5:0] == a.daydate);
		case ({a.second_alarm_daydate_mask, a.second_alarm_hour_mask,
				a.second_alarm_minute_mask})
			3'h7:    a2_hit = t.sec == SEC_ZERO;
			3'h6:    a2_hit = t.sec == SEC_ZERO && mn;
			3'h4:    a2_hit = t.sec == SEC_ZERO && mn && hr;
			3'h0:    a2_hit = t.sec == SEC_ZERO && mn && hr && dd;
			default: a2_hit = 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] rd_byte(input logic [7:0] ptr, input rac_ctrl_t c,
			input logic [1:0] f, input logic [7:0] ext);
		case (ptr)
			ADDR_CTRL: rd_byte = c;
			ADDR_STAT: rd_byte = {STAT_PAD, f};
			default:   rd_byte = ext;
		endcase
	endfunction

	assign a2_now    = a2_hit(time_i, alarm2_cfg_i);
	assign alarm_set = tick_d_reg ? {a2_now, first_alarm_match_i} : 2'h0;

	// Serial slave state
	rac_bus_st_t st_reg;
	rac_bus_st_t st_next;
	logic [3:0]  bit_reg;
	logic [3:0]  bit_next;
	logic [7:0]  sh_reg;
	logic [7:0]  sh_next;
	logic [7:0]  ptr_reg;
	logic [7:0]  ptr_next;
	logic        rw_reg;
	logic        rw_next;
	logic        first_reg;
	logic        first_next;
	logic        oe_reg;
	logic        oe_next;
	logic        ewr_reg;
	logic        ewr_next;
	logic [7:0]  ewa_reg;
	logic [7:0]  ewa_next;
	logic [7:0]  ewd_reg;
	logic [7:0]  ewd_next;
	logic [7:0]  rd_now;

	assign rd_now = rd_byte(ptr_reg, ctrl_reg, flag_reg, ext_rdata_i);

	always_comb begin
		st_next    = st_reg;
		bit_next   = bit_reg;
		sh_next    = sh_reg;
		ptr_next   = ptr_reg;
		rw_next    = rw_reg;
		first_next = first_reg;
		oe_next    = oe_reg;
		ctrl_next  = ctrl_reg;
		flag_next  = flag_reg;
		ewr_next   = 1'b0;
		ewa_next   = ewa_reg;
		ewd_next   = ewd_reg;
		if (stop_ev) begin
			st_next = ST_IDLE;
			oe_next = 1'b0;
		end else if (start_ev) begin
			st_next  = ST_ADDR;
			bit_next = 4'h0;
			oe_next  = 1'b0;
		end else if (scl_rise) begin
			case (st_reg)
				ST_ADDR, ST_WRITE: begin
					sh_next  = {sh_reg[6:0], lvl_reg[2]};
					bit_next = bit_reg + 4'h1;
				end
				ST_MACK: begin
					ptr_next = ptr_reg + 8'h01;
					if (lvl_reg[2]) begin
						st_next = ST_IDLE;
					end
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (st_reg)
				ST_ADDR: begin
					if (bit_reg == BYTE_BITS) begin
						if (sh_reg[7:1] == SLAVE_ADDR) begin
							st_next    = ST_ACK;
							oe_next    = 1'b1;
							rw_next    = sh_reg[0];
							first_next = 1'b1;
						end else begin
							st_next = ST_IDLE;
						end
					end
				end
				ST_WRITE: begin
					if (bit_reg == BYTE_BITS) begin
						st_next = ST_ACK;
						oe_next = 1'b1;
						if (first_reg) begin
							ptr_next   = sh_reg;
							first_next = 1'b0;
						end else begin
							ptr_next = ptr_reg + 8'h01;
							if (ptr_reg == ADDR_CTRL) begin
								ctrl_next = sh_reg;
							end else if (ptr_reg == ADDR_STAT) begin
								flag_next = flag_reg & sh_reg[1:0];
							end else begin
								ewr_next = 1'b1;
								ewa_next = ptr_reg;
								ewd_next = sh_reg;
							end
						end
					end
				end
				ST_ACK: begin
					if (rw_reg) begin
						st_next  = ST_READ;
						sh_next  = rd_now;
						oe_next  = !rd_now[7];
						bit_next = 4'h1;
					end else begin
						st_next  = ST_WRITE;
						oe_next  = 1'b0;
						bit_next = 4'h0;
					end
				end
				ST_READ: begin
					if (bit_reg == BYTE_BITS) begin
						st_next = ST_MACK;
						oe_next = 1'b0;
					end else begin
						sh_next  = {sh_reg[6:0], 1'b0};
						oe_next  = !sh_reg[6];
						bit_next = bit_reg + 4'h1;
					end
				end
				ST_MACK: begin
					st_next  = ST_READ;
					sh_next  = rd_now;
					oe_next  = !rd_now[7];
					bit_next = 4'h1;
				end
				default: begin
					st_next = ST_IDLE;
				end
			endcase
		end
		flag_next = flag_next | alarm_set;
		if (ctrl_reg.output_routing_select) begin
			out_next = !(|(flag_reg & {ctrl_reg.second_alarm_irq_enable,
				ctrl_reg.first_alarm_irq_enable}));
		end else begin
			out_next = sqw;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			st_reg     <= ST_IDLE;
			bit_reg    <= 4'h0;
			sh_reg     <= 8'h00;
			ptr_reg    <= 8'h00;
			rw_reg     <= 1'b0;
			first_reg  <= 1'b0;
			oe_reg     <= 1'b0;
			ctrl_reg   <= CTRL_RESET;
			flag_reg   <= FLAGS_RESET;
			ewr_reg    <= 1'b0;
			ewa_reg    <= 8'h00;
			ewd_reg    <= 8'h00;
			tick_d_reg <= 1'b0;
			out_reg    <= 1'b1;
		end else begin
			st_reg     <= st_next;
			bit_reg    <= bit_next;
			sh_reg     <= sh_next;
			ptr_reg    <= ptr_next;
			rw_reg     <= rw_next;
			first_reg  <= first_next;
			oe_reg     <= oe_next;
			ctrl_reg   <= ctrl_next;
			flag_reg   <= flag_next;
			ewr_reg    <= ewr_next;
			ewa_reg    <= ewa_next;
			ewd_reg    <= ewd_next;
			tick_d_reg <= tick;
			out_reg    <= out_next;
		end
	end

	// Open-drain data: only ever pulls low
	assign sda_o               = 1'b0;
	assign sda_oe_o            = oe_reg;
	assign square_or_irq_out_o = out_reg;
	assign second_tick_o       = tick;
	assign reg_ptr_o           = ptr_reg;
	assign ext_wr_o            = ewr_reg;
	assign ext_waddr_o         = ewa_reg;
	assign ext_wdata_o         = ewd_reg;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	chk_alarm2_sets: assert property (tick_d_reg && a2_now |=> flag_reg[1])
		else $error("alarm 2 match did not set its flag");
	chk_daydate_pick: assert property (tick_d_reg && !flag_reg[1]
		&& {alarm2_cfg_i.second_alarm_daydate_mask, alarm2_cfg_i.second_alarm_hour_mask,
		alarm2_cfg_i.second_alarm_minute_mask} == 3'h0
		&& (alarm2_cfg_i.weekday_or_monthday_select ? time_i.day[5:0] != alarm2_cfg_i.daydate
		: time_i.date[5:0] != alarm2_cfg_i.daydate) |=> !flag_reg[1])
		else $error("day or date compare used the wrong field");
	chk_hold_divider: assert property (!ctrl_reg.timebase_enable ##1
		!ctrl_reg.timebase_enable |-> !tick)
		else $error("tick while timebase disabled");
	chk_reset_ctrl: assert property ($fell(reset_i) |-> ctrl_reg == CTRL_RESET
		&& out_reg && !sda_oe_o)
		else $error("control defaults wrong after reset");
	chk_flag_write: assert property (scl_fall && st_reg == ST_WRITE && !first_reg
		&& bit_reg == BYTE_BITS && ptr_reg == ADDR_STAT && !tick_d_reg
		|=> flag_reg == ($past(flag_reg) & $past(sh_reg[1:0])))
		else $error("status write did not clear only zero bits");
	chk_irq_low: assert property (ctrl_reg.output_routing_select && |(flag_reg
		& {ctrl_reg.second_alarm_irq_enable, ctrl_reg.first_alarm_irq_enable})
		##1 ctrl_reg.output_routing_select |-> !square_or_irq_out_o)
		else $error("interrupt not asserted for enabled flag");
	chk_sqw_route: assert property (!ctrl_reg.output_routing_select
		|=> square_or_irq_out_o == $past(sqw))
		else $error("square wave not routed to shared pin");
	chk_ack_drive: assert property (st_reg == ST_ACK |-> sda_oe_o)
		else $error("data line not held low during acknowledge");
	chk_nack_free: assert property (st_reg == ST_MACK |-> !sda_oe_o)
		else $error("slave drove the line during master acknowledge");
	chk_ptr_step: assert property (scl_fall && st_reg == ST_WRITE && !first_reg
		&& bit_reg == BYTE_BITS && !stop_ev && !start_ev
		|=> ptr_reg == $past(ptr_reg) + 8'h01)
		else $error("pointer did not step after data byte");

	cov_alarm2: cover property (tick_d_reg && a2_now ##1 flag_reg[1]);
	cov_read: cover property (st_reg == ST_READ ##[1:400] st_reg == ST_MACK);
	cov_ctrl_wr: cover property (ctrl_reg != $past(ctrl_reg));
endmodule
`default_nettype wire

//--- sim/rac_master.sv
// Serial bus master model driving the clock directly, data open-drain via the bench's wired-AND
`timescale 1ns/100ps
`default_nettype none
module rac_master (
	// Clock
	input  wire logic clock_i,
	// Bus lines
	input  wire logic sda_line_i,
	output logic      scl_o,
	output logic      sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	task automatic hp(input int n);
		repeat (n) @(negedge clock_i);
	endtask

	task automatic start();
		sda_o = 1'b1;
		// Long low phase: slave drops its acknowledge about four clocks after the fall
		hp(6);
		scl_o = 1'b1;
		hp(8);
		sda_o = 1'b0;
		hp(8);
		scl_o = 1'b0;
	endtask

	task automatic stop();
		hp(2);
		sda_o = 1'b0;
		hp(8);
		scl_o = 1'b1;
		hp(8);
		sda_o = 1'b1;
		hp(8);
	endtask

	// Data set while clock low, sampled at end of high phase
	task automatic bitx(input logic b, output logic r);
		hp(2);
		sda_o = b;
		hp(8);
		scl_o = 1'b1;
		hp(8);
		r = sda_line_i;
		scl_o = 1'b0;
	endtask

	task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q,
			output logic a);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(ack, a);
	endtask
endmodule
`default_nettype wire

//--- sim/rtc_alarm_sqw_control_i2c_test.sv
// Self-checking bench of the alarm, timebase and serial control block
`timescale 1ns/100ps
`default_nettype none
module rtc_alarm_sqw_control_i2c_test;
	import rac_pkg::*;
	localparam int TBP = 20;
	logic        clock_i    = 1'b0;
	logic        reset_i    = 1'b1;
	logic        timebase_i = 1'b0;
	logic        a1m        = 1'b0;
	logic        m_scl;
	logic        m_sda;
	logic        sda_o;
	logic        sda_oe_o;
	logic        pin;
	logic        tick;
	logic        ext_wr;
	rac_time_t   t          = '0;
	rac_alarm2_t cfg        = '0;
	logic [7:0]  ptr;
	logic [7:0]  ext_rd;
	logic [7:0]  waddr;
	logic [7:0]  wdata;
	logic [7:0]  wa;
	logic [7:0]  wd;
	logic [31:0] seed       = 32'd58;
	int          error_cnt  = 0;
	int          cmp_count  = 0;
	int          tbc        = 0;
	wire logic   sda_line   = m_sda & ~(sda_oe_o & ~sda_o);

	assign ext_rd = ptr ^ 8'h5A;

	always #50 clock_i = ~clock_i;

	always @(negedge clock_i) begin
		tbc <= (tbc == TBP / 2 - 1) ? 0 : tbc + 1;
		if (tbc == TBP / 2 - 1) timebase_i <= ~timebase_i;
	end

	always @(negedge clock_i) begin
		if (ext_wr === 1'b1) begin
			wa <= waddr;
			wd <= wdata;
		end
	end

	rac_rtc_ctrl DUT (.clock_i(clock_i), .reset_i(reset_i), .timebase_i(timebase_i),
		.scl_i(m_scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.square_or_irq_out_o(pin), .time_i(t), .alarm2_cfg_i(cfg),
		.first_alarm_match_i(a1m), .second_tick_o(tick), .reg_ptr_o(ptr),
		.ext_rdata_i(ext_rd), .ext_wr_o(ext_wr), .ext_waddr_o(waddr),
		.ext_wdata_o(wdata));

	rac_master m (.clock_i(clock_i), .sda_line_i(sda_line), .scl_o(m_scl), .sda_o(m_sda));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic exp2(input rac_time_t tt, input rac_alarm2_t ac);
		logic mm;
		logic hm;
		logic dm;
		logic f;
		mm = tt.min[6:0] == ac.min;
		hm = tt.hour[6:0] == ac.hour;
		dm = (ac.weekday_or_monthday_select ? tt.day[5:0] : tt.date[5:0]) == ac.daydate;
		case ({ac.second_alarm_minute_mask, ac.second_alarm_hour_mask,
				ac.second_alarm_daydate_mask})
			3'b111: f = 1'b1;
			3'b011: f = mm;
			3'b001: f = mm & hm;
			3'b000: f = mm & hm & dm;
			default: f = 1'b0;
		endcase
		return (tt.sec == 8'h00) & f;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
		logic [7:0] q;
		logic a;
		m.start();
		m.xfer(8'hD0, 1'b1, q, a);
		check(a, 0);
		m.xfer(p, 1'b1, q, a);
		check(a, 0);
		foreach (d[i]) begin
			m.xfer(d[i], 1'b1, q, a);
			check(a, 0);
		end
		m.stop();
	endtask

	task automatic rd(input logic set, input logic [7:0] p, input int n,
			output logic [7:0] r[$]);
		logic [7:0] q;
		logic a;
		if (set) begin
			m.start();
			m.xfer(8'hD0, 1'b1, q, a);
			m.xfer(p, 1'b1, q, a);
		end
		m.start();
		m.xfer(8'hD1, 1'b1, q, a);
		check(a, 0);
		r = {};
		for (int i = 0; i < n; i++) begin
			m.xfer(8'hFF, i == n - 1, q, a);
			r.push_back(q);
		end
		m.hp(6);
		check(sda_oe_o, 0);
		m.stop();
	endtask

	// Clocks between two rising edges of the pin or the tick, 0 if none
	task automatic per(input logic w, output int n);
		int k = 0;
		int g = 0;
		logic v;
		logic pv = 1'b1;
		n = 0;
		while (k < 2 && g < 4000) begin
			@(negedge clock_i);
			g++;
			v = w ? tick : pin;
			if (k > 0) n++;
			if (v === 1'b1 && pv === 1'b0) k++;
			pv = v;
		end
		if (k < 2) n = 0;
	endtask

	task automatic wait_tick();
		int n = 0;
		while (tick !== 1'b1 && n < 2000) begin
			@(negedge clock_i);
			n++;
		end
		check(n < 2000, 1);
	endtask

	initial begin
		#10000000;
		error_cnt++;
		report_and_stop();
	end

	initial begin
		logic [7:0] r[$];
		logic [7:0] c;
		logic [7:0] s;
		logic [7:0] p;
		logic [1:0] e;
		logic a;
		int n;
		logic [7:0] tc[6];
		int te[6];
		tc = '{8'h88, 8'h90, 8'h98, 8'hF8, 8'hF8, 8'hD8};
		te = '{32, 8, 4, 50, 50, 60};
		t.sec = 8'h01;
		repeat (20) @(negedge clock_i);
		reset_i = 1'b0;
		repeat (5) @(negedge clock_i);
		rd(1, ADDR_CTRL, 2, r);
		check(r[0], 8'h98);
		check(r[1], 8'h00);
		m.start();
		m.xfer(8'hD2, 1'b1, c, a);
		check(a, 1);
		m.stop();
		p = 8'h10 | (8'(rnd()) & 8'h0F);
		c = 8'(rnd());
		wr(p, '{c, ~c, c ^ 8'h3C});
		check({wa, wd}, {p + 8'h02, c ^ 8'h3C});
		rd(0, 8'h00, 1, r);
		check(r[0], (p + 8'h03) ^ 8'h5A);
		s = 8'(rnd());
		c = {3'b111, s[4:0]};
		wr(ADDR_CTRL, '{c, 8'hFF});
		rd(1, ADDR_CTRL, 2, r);
		check({r[0], r[1]}, {c, 8'h00});
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_CTRL, '{tc[i]});
			per(i > 3, n);
			check(n, te[i] * TBP);
		end
		// 8192 Hz input: 1 Hz wave whatever the rate bits, so no full period here
		wr(ADDR_CTRL, '{8'hB8});
		per(0, n);
		check(n, 0);
		wr(ADDR_CTRL, '{8'h78});
		per(1, n);
		check(n, 0);
		wr(ADDR_CTRL, '{8'hF8});
		n = 0;
		while (tick !== 1'b1 && n < 2000) begin
			@(negedge clock_i);
			n++;
		end
		check(n >= 900 && n <= 51 * TBP, 1);
		for (int i = 0; i < 10; i++) begin
			t.sec = 8'h01;
			a1m = 1'b0;
			s = 8'(rnd());
			c = {5'b11111, s[7], 2'(rnd())};
			wr(ADDR_CTRL, '{c, 8'h00});
			if (c[2]) check(pin, 1);
			cfg = 24'(rnd());
			{cfg.second_alarm_minute_mask, cfg.second_alarm_hour_mask,
				cfg.second_alarm_daydate_mask} = 3'b111 >> s[1:0];
			t = {8'h00, 1'b0, cfg.min, 1'b0, cfg.hour, 2'b00, cfg.daydate,
				2'b00, cfg.daydate};
			if (s[2]) t = t ^ (40'h1 << (8 * s[4:3]));
			t.sec = s[6] ? 8'h01 : 8'h00;
			a1m = s[5];
			wait_tick();
			repeat (4) @(negedge clock_i);
			e = {exp2(t, cfg), a1m};
			if (c[2]) check(pin, ~|(e & c[1:0]));
			wr(ADDR_STAT, '{8'hFF});
			rd(1, ADDR_STAT, 1, r);
			check(r[0], {6'h00, e});
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
